/* core/ssl_top.sv */
// Synthesizer serial load port, latches, power and alignment control
//
// How it works
// - Power enable low forces power-down immediately, without a clock.
// - Power enable high leaves power-down unless function bit 3 (soft power-down) is set; both dividers restart together.
// - Latch contents survive power enable cycling.
// - Counter reset holds dividers, tristates charge pump, no power-down.
// - Load strobe rising edge moves the last 24 shifted bits to a latch.
// - Serial data shifts in MSB first on rising serial clock.
// - Two low word bits pick reference, feedback or function latch.
// - Function bit 2 is the counter reset holding both dividers.
// - Shifting and latching keep working during any power-down.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module ssl_top #(
   parameter int WORD_BITS = ssl_pkg::WORD_BITS
) (
   // APB clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        pclk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial link pins
   input  wire logic        sclk,
   input  wire logic        sdata,
   input  wire logic        load_strobe,
   // Power enable pin
   input  wire logic        power_enable,
   // Block controls
   output logic             power_down,
   output logic             dividers_hold,
   output logic             cp_tristate,
   output logic             dividers_align,
   output logic [23:0]      ref_word,
   output logic [23:0]      fb_word,
   output logic [23:0]      func_word
);
   typedef struct packed {
      logic [23:0]           ref_latch;
      logic [23:0]           fb_latch;
      logic [23:0]           func_latch;
      logic                  tog_seen;
      logic                  cr_prev;
      logic                  pd_prev;
      logic                  align;
      logic [15:0]           word_count;
      logic [15:0]           settle;
      ssl_pkg::ssl_power_type power;
      logic [31:0]           rdata;
   } ssl_core_type;

   localparam logic [15:0] SETTLE_LOAD = 16'(ssl_pkg::SETTLE_CYCLES);

   ssl_core_type state;
   ssl_core_type next_state;
   ssl_word_if   word_bus ();
   logic         tog_sync;
   logic         en_sync;
   logic         pd_async;
   logic [1:0]   sel;
   logic         new_word;
   logic         apb_access;
   logic         addr_ok;
   logic         pd_now;

   // Link side runs on the serial clock, independent of power state
   ssl_shifter #(
      .WIDTH       (WORD_BITS)
   ) u_shifter (
      .sclk        (sclk),
      .sdata       (sdata),
      .load_strobe (load_strobe),
      .presetn     (presetn),
      .wo          (word_bus.link)
   );

   // Event toggle crosses as a level; word is stable well before it changes
   ssl_sync #(
      .WIDTH   (1)
   ) u_tog_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pclk_en (pclk_en),
      .din     (word_bus.toggle),
      .dout    (tog_sync)
   );

   // Power enable pin synchronised for the state machine
   ssl_sync #(
      .WIDTH   (1)
   ) u_en_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pclk_en (pclk_en),
      .din     (power_enable),
      .dout    (en_sync)
   );

   // Decode of an arriving word
   assign new_word   = tog_sync ^ state.tog_seen;
   assign sel        = word_bus.word[ssl_pkg::SEL_LSB +: ssl_pkg::SEL_BITS];
   assign apb_access = psel & penable;
   assign addr_ok    = (paddr == ssl_pkg::ADDR_REF) | (paddr == ssl_pkg::ADDR_FB) |
                       (paddr == ssl_pkg::ADDR_FUNC) | (paddr == ssl_pkg::ADDR_STATUS) |
                       (paddr == ssl_pkg::ADDR_COUNT);

   // Pin low acts combinationally, no clock edge needed
   assign pd_async = ~power_enable;

   always_comb begin
      next_state = state;
      if (pclk_en) begin
         next_state.align = 1'b0;
         // Latch transfer stays live in every power state
         if (new_word) begin
            next_state.tog_seen   = tog_sync;
            next_state.word_count = state.word_count + 16'h0001;
            case (sel)
               ssl_pkg::SEL_REF: begin
                  next_state.ref_latch = word_bus.word;
               end
               ssl_pkg::SEL_FB: begin
                  next_state.fb_latch = word_bus.word;
               end
               ssl_pkg::SEL_FUNC: begin
                  next_state.func_latch = word_bus.word;
               end
               default: begin
                  next_state.ref_latch = state.ref_latch;
               end
            endcase
         end
         // Power sequencing; latches untouched by it
         case (state.power)
            ssl_pkg::PW_DOWN: begin
               next_state.settle = SETTLE_LOAD;
               if (en_sync && !state.func_latch[ssl_pkg::SOFT_PD_POS]) begin
                  next_state.power = ssl_pkg::PW_SETTLE;
               end
            end
            ssl_pkg::PW_SETTLE: begin
               if (!en_sync || state.func_latch[ssl_pkg::SOFT_PD_POS]) begin
                  next_state.power = ssl_pkg::PW_DOWN;
               end else if (state.settle <= 16'h0001) begin
                  next_state.power = ssl_pkg::PW_RUN;
               end else begin
                  next_state.settle = state.settle - 16'h0001;
               end
            end
            ssl_pkg::PW_RUN: begin
               if (!en_sync || state.func_latch[ssl_pkg::SOFT_PD_POS]) begin
                  next_state.power = ssl_pkg::PW_DOWN;
               end
            end
            default: begin
               next_state.power = ssl_pkg::PW_DOWN;
            end
         endcase
         // Release of either hold restarts both dividers in the same cycle
         next_state.cr_prev = state.func_latch[ssl_pkg::CNT_RESET_POS];
         next_state.pd_prev = pd_now;
         if ((state.cr_prev && !state.func_latch[ssl_pkg::CNT_RESET_POS] && !pd_now) ||
             (state.pd_prev && !pd_now && !state.func_latch[ssl_pkg::CNT_RESET_POS])) begin
            next_state.align = 1'b1;
         end
         // APB read data captured in setup phase
         if (psel && !penable && !pwrite) begin
            case (paddr)
               ssl_pkg::ADDR_REF:    next_state.rdata = {8'h00, state.ref_latch};
               ssl_pkg::ADDR_FB:     next_state.rdata = {8'h00, state.fb_latch};
               ssl_pkg::ADDR_FUNC:   next_state.rdata = {8'h00, state.func_latch};
               ssl_pkg::ADDR_STATUS: next_state.rdata = {27'h0000000, en_sync, state.align,
                                                         cp_tristate, dividers_hold, pd_now};
               ssl_pkg::ADDR_COUNT:  next_state.rdata = {16'h0000, state.word_count};
               default:              next_state.rdata = 32'h00000000;
            endcase
         end
         // Writes to the count register clear it; the serial port wins a tie
         if (apb_access && pwrite && paddr == ssl_pkg::ADDR_COUNT && !new_word) begin
            next_state.word_count = 16'h0000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state.ref_latch  <= ssl_pkg::REF_RESET;
         state.fb_latch   <= ssl_pkg::FB_RESET;
         state.func_latch <= ssl_pkg::FUNC_RESET;
         state.tog_seen   <= 1'b0;
         state.cr_prev    <= 1'b0;
         state.pd_prev    <= 1'b1;
         state.align      <= 1'b0;
         state.word_count <= 16'h0000;
         state.settle     <= 16'h0000;
         state.power      <= ssl_pkg::PW_DOWN;
         state.rdata      <= 32'h00000000;
      end else begin
         state <= next_state;
      end
   end

   // Power-down: pin, soft bit or settling; counter reset never adds to it
   assign pd_now = pd_async | (state.power != ssl_pkg::PW_RUN);
   assign power_down = pd_now;
   // Dividers held at load point by counter reset or power-down
   assign dividers_hold = state.func_latch[ssl_pkg::CNT_RESET_POS] | pd_now;
   // Charge pump tristated by reset, power-down or its own bit
   assign cp_tristate = state.func_latch[ssl_pkg::CNT_RESET_POS] | pd_now |
                        state.func_latch[ssl_pkg::CP_TRI_POS];
   assign dividers_align = state.align;
   assign ref_word  = state.ref_latch;
   assign fb_word   = state.fb_latch;
   assign func_word = state.func_latch;

   // APB answers in the first access cycle
   assign pready  = 1'b1;
   assign pslverr = apb_access & ~addr_ok;
   assign prdata  = state.rdata;
endmodule // ssl_top

/* include/ssl_pkg.sv */
// Shared constants and types for the synthesizer serial load block
package ssl_pkg;
   // Word layout
   localparam int WORD_BITS      = 24;
   localparam int SEL_LSB        = 0;
   localparam int SEL_BITS       = 2;
   localparam int CNT_RESET_POS  = 2;
   localparam int SOFT_PD_POS    = 3;
   localparam int CP_TRI_POS     = 8;
   // Latch select codes
   localparam logic [1:0] SEL_REF  = 2'h0;
   localparam logic [1:0] SEL_FB   = 2'h1;
   localparam logic [1:0] SEL_FUNC = 2'h2;
   localparam logic [1:0] SEL_NONE = 2'h3;
   // Reset values
   localparam logic [23:0] REF_RESET  = 24'h000000;
   localparam logic [23:0] FB_RESET   = 24'h000001;
   localparam logic [23:0] FUNC_RESET = 24'h000002;
   // APB register byte offsets
   localparam logic [11:0] ADDR_REF    = 12'h000;
   localparam logic [11:0] ADDR_FB     = 12'h004;
   localparam logic [11:0] ADDR_FUNC   = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00C;
   localparam logic [11:0] ADDR_COUNT  = 12'h010;
   // Status bit positions
   localparam int ST_PD      = 0;
   localparam int ST_CRESET  = 1;
   localparam int ST_CPTRI   = 2;
   localparam int ST_ALIGN   = 3;
   localparam int ST_ENABLE  = 4;
   // Settling time after power enable rises, in ns, and clock rate in MHz
   localparam int SETTLE_NS     = 1000;
   localparam int PCLK_MHZ      = 250;
   localparam int SETTLE_CYCLES = (SETTLE_NS * PCLK_MHZ + 999) / 1000;
   // Power state machine
   typedef enum logic [2:0] {
      PW_DOWN   = 3'b001,
      PW_SETTLE = 3'b010,
      PW_RUN    = 3'b100
   } ssl_power_type;
endpackage

/* include/ssl_word_if.sv */
// Word transfer from link shifter to the core latches
`timescale 1ns/10ps
interface ssl_word_if;
   logic [23:0] word;
   logic        toggle;
   modport link (output word, output toggle);
   modport core (input word, input toggle);
endinterface

/* core/ssl_shifter.sv */
// Serial shift register and load strobe capture on the link clock
`timescale 1ns/10ps
module ssl_shifter #(
   parameter int WIDTH = 24
) (
   // Link pins
   input  wire logic sclk,
   input  wire logic sdata,
   input  wire logic load_strobe,
   input  wire logic presetn,
   // Word out
   ssl_word_if.link  wo
);
   // Shift state on the serial clock; capture sits apart on the strobe clock
   typedef struct packed {
      logic [WIDTH-1:0] shift;
   } ssl_shift_type;

   ssl_shift_type    state;
   ssl_shift_type    next_state;
   logic [WIDTH-1:0] cap_word;
   logic             cap_toggle;

   // Shift MSB first on each rising serial clock
   always_comb begin
      next_state       = state;
      next_state.shift = {state.shift[WIDTH-2:0], sdata};
   end

   always_ff @(posedge sclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Strobe edge captures the word and flips the event toggle
   always_ff @(posedge load_strobe or negedge presetn) begin
      if (!presetn) begin
         cap_word   <= '0;
         cap_toggle <= 1'b0;
      end else begin
         cap_word   <= state.shift;
         cap_toggle <= ~cap_toggle;
      end
   end

   // Word held steady until the next strobe, so only the toggle needs syncing
   assign wo.word   = cap_word;
   assign wo.toggle = cap_toggle;
endmodule // ssl_shifter

/* core/ssl_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/10ps
module ssl_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             pclk_en,
   // Data
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } ssl_sync_type;

   ssl_sync_type state;
   ssl_sync_type next_state;

   // First stage feeds only the second
   always_comb begin
      next_state = state;
      if (pclk_en) begin
         next_state.meta = din;
         next_state.sync = state.meta;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign dout = state.sync;
endmodule // ssl_sync

/* tb/ssl_host_model.sv */
// Serial host model: drives a byte-wise 24-bit load with idle-low clock
`timescale 1ns/10ps
module ssl_host_model (
   // Link pins
   output logic sclk,
   output logic sdata,
   output logic load_strobe
);
   initial begin
      sclk = 1'b0;
      sdata = 1'b0;
      load_strobe = 1'b1;
   end

   // Three bytes, MSB first, 160 ns clock only inside the frame
   task automatic send(input logic [23:0] w);
      int b;
      int k;
      #1.3 load_strobe = 1'b0;
      for (b = 0; b < 3; b++) begin
         for (k = 0; k < 8; k++) begin
            sdata = w[23 - 8 * b - k];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
         end
      end
      #80 load_strobe = 1'b1;
      // Released data line shows the inverse, not the last bit
      sdata = ~sdata;
      #320;
   endtask
endmodule // ssl_host_model

/* tb/ssl_checker.sv */
// Port-level assertions for the serial load block
`timescale 1ns/10ps
module ssl_checker #(
   parameter int WORD_BITS = 24
) (
   // Clock and reset
   input wire logic                 pclk,
   input wire logic                 presetn,
   // Power and divider controls
   input wire logic                 power_enable,
   input wire logic                 power_down,
   input wire logic                 dividers_hold,
   input wire logic                 cp_tristate,
   input wire logic                 dividers_align,
   // Latch contents
   input wire logic [WORD_BITS-1:0] ref_word,
   input wire logic [WORD_BITS-1:0] fb_word,
   input wire logic [WORD_BITS-1:0] func_word
);
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Pin low must win over any state machine
   pd_pin_a: assert property (!power_enable |-> power_down)
      else $error("power_down low while enable pin low");
   pd_hold_a: assert property (power_down |-> dividers_hold && cp_tristate)
      else $error("power-down without divider hold");
   cr_hold_a: assert property (func_word[2] |-> dividers_hold && cp_tristate)
      else $error("counter reset without hold");
   cr_no_pd_a: assert property ((power_enable && !func_word[3] && !power_down) |=> (!power_down || !power_enable || func_word[3]))
      else $error("unexpected power-down");
   align_rise_a: assert property ($fell(dividers_hold) |-> ##[0:1] dividers_align)
      else $error("no align pulse after hold release");
   align_pulse_a: assert property (dividers_align |=> !dividers_align)
      else $error("align longer than one cycle");
   // A latch may only change to a word carrying its own select code
   ref_sel_a: assert property ($changed(ref_word) |-> ref_word[1:0] == ssl_pkg::SEL_REF)
      else $error("reference latch took wrong select");
   fb_sel_a: assert property ($changed(fb_word) |-> fb_word[1:0] == ssl_pkg::SEL_FB)
      else $error("feedback latch took wrong select");
   func_sel_a: assert property ($changed(func_word) |-> func_word[1:0] == ssl_pkg::SEL_FUNC)
      else $error("function latch took wrong select");
   keep_pe_a: assert property ($changed(power_enable) |-> $stable(ref_word) && $stable(fb_word))
      else $error("latch lost on enable toggle");
endmodule // ssl_checker

bind ssl_top ssl_checker #(.WORD_BITS(WORD_BITS)) chk_u (.pclk(pclk), .presetn(presetn),
   .power_enable(power_enable), .power_down(power_down), .dividers_hold(dividers_hold),
   .cp_tristate(cp_tristate), .dividers_align(dividers_align), .ref_word(ref_word),
   .fb_word(fb_word), .func_word(func_word));

/* tb/ssl_top_bench.sv */
// Self-checking bench: APB reads and serial loads through the host model
`timescale 1ns/10ps
module ssl_top_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
   logic        power_enable, power_down, dividers_hold, cp_tristate, sclk, sdata, load_strobe;
   logic        dividers_align;
   int          n_align;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_data;
   logic [23:0] ref_word, fb_word, func_word;
   int          n_errors, tests_run;

   ssl_top dut_u (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sclk(sclk), .sdata(sdata), .load_strobe(load_strobe),
      .power_enable(power_enable), .power_down(power_down), .dividers_hold(dividers_hold),
      .cp_tristate(cp_tristate), .dividers_align(dividers_align), .ref_word(ref_word), .fb_word(fb_word),
      .func_word(func_word));
   ssl_host_model host_u (.sclk(sclk), .sdata(sdata), .load_strobe(load_strobe));

   // Clock
   initial pclk = 1'b0;
   always #2 pclk = ~pclk;

   // Align pulses last one cycle, so count them as they pass
   initial n_align = 0;
   always @(posedge pclk) begin
      if (dividers_align === 1'b1) begin
         n_align++;
      end
   end

   task end_sim;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         n_errors++;
      end
   endtask

   // One APB transfer; data and error taken at the pready edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 50);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 50) begin n_errors++; end_sim(); end
   endtask

   // Serial load, then room for the strobe to cross into pclk
   task sw(input logic [23:0] w);
      host_u.send(w);
      repeat (8) @(posedge pclk);
   endtask

   // Wait for the settle period after the enable pin rises
   task wait_up;
      int i;
      i = 0;
      while (power_down !== 1'b0 && i < 2000) begin @(posedge pclk); i++; end
      if (i >= 2000) begin n_errors++; end_sim(); end
   endtask

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h00000000; power_enable = 1'b1;
      n_errors = 0; tests_run = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      check({8'h00, func_word}, {8'h00, ssl_pkg::FUNC_RESET});
      wait_up();
      // Counter reset method
      sw(24'h000006);
      check({29'h0, dividers_hold, cp_tristate, power_down}, 32'h00000006);
      sw(24'hA5A5A4);
      sw(24'h3C3C3D);
      check({8'h00, ref_word}, 32'h00A5A5A4);
      check({8'h00, fb_word}, 32'h003C3C3D);
      apb(1'b0, ssl_pkg::ADDR_FB, 32'h00000000);
      check(rd_data, 32'h003C3C3D);
      sw(24'h000002);
      check({30'h0, dividers_hold, cp_tristate}, 32'h00000000);
      // Select 11 changes no latch
      apb(1'b1, ssl_pkg::ADDR_COUNT, 32'h00000000);
      sw(24'hFFFFFF);
      check({8'h00, ref_word ^ fb_word ^ func_word}, 32'h0099999B);
      apb(1'b0, ssl_pkg::ADDR_COUNT, 32'h00000000);
      check(rd_data, 32'h00000001);
      // Pin method: load all three latches while powered down
      power_enable <= 1'b0;
      @(posedge pclk);
      #1 check({31'h0, power_down}, 32'h00000001);
      sw(24'h000102);
      sw(24'h000408);
      sw(24'h000811);
      check({8'h00, func_word ^ ref_word ^ fb_word}, 32'h00000D1B);
      power_enable <= 1'b1;
      wait_up();
      check({30'h0, dividers_hold, cp_tristate}, 32'h00000001);
      check({8'h00, ref_word}, 32'h00000408);
      apb(1'b0, ssl_pkg::ADDR_STATUS, 32'h00000000);
      check(rd_data, (32'h1 << ssl_pkg::ST_ENABLE) | (32'h1 << ssl_pkg::ST_CPTRI));
      // Soft power-down bit in the function latch
      sw(24'h00010A);
      check({31'h0, power_down}, 32'h00000001);
      check({30'h0, dividers_hold, cp_tristate}, 32'h00000003);
      // One pulse each: first power-up, counter reset release, pin power-up
      check(n_align, 32'h00000003);
      // Unmapped address
      apb(1'b0, 12'h020, 32'h00000000);
      check({31'h0, rd_err}, 32'h00000001);
      check(rd_data, 32'h00000000);
      end_sim();
   end
endmodule // ssl_top_bench
